// ### common/lcd_mode_pkg.sv
// Register map, field layout and carrier types of the mode and power block
package lcd_mode_pkg;
    localparam int         ADDR_W          = 8;
    localparam int         PIX_W_DOC       = 12;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_DISP_MODE   = 8'h02;
    localparam logic [7:0] IDX_PWR_MODE    = 8'h03;
    localparam logic [7:0] IDX_PANEL_CFG   = 8'h04;
    localparam logic [7:0] IDX_STATUS      = 8'h05;
    localparam logic [7:0] ADDR_DISP_MODE  = 8'(IDX_DISP_MODE * 4);
    localparam logic [7:0] ADDR_PWR_MODE   = 8'(IDX_PWR_MODE * 4);
    localparam logic [7:0] ADDR_PANEL_CFG  = 8'(IDX_PANEL_CFG * 4);
    localparam logic [7:0] ADDR_STATUS     = 8'(IDX_STATUS * 4);
    // Display mode fields
    localparam int         DM_BPP_LO       = 6;
    localparam int         DM_HIGH_PERF    = 5;
    localparam int         DM_CLK_DIV      = 4;
    localparam int         DM_BLANK        = 3;
    localparam int         DM_FRAME_REP    = 2;
    localparam int         DM_HW_INV       = 1;
    localparam int         DM_SW_INV       = 0;
    // Power mode fields
    localparam int         PM_OVERRIDE     = 3;
    localparam int         PM_HW_PS        = 2;
    localparam int         PM_SW_PS_LO     = 0;
    localparam logic [7:0] PM_USED_MASK    = 8'h0F;
    // Panel configuration fields
    localparam int         PC_ACTIVE       = 0;
    localparam int         PC_COLOUR       = 1;
    localparam int         PC_PORTRAIT     = 2;
    localparam int         PC_IO0_DIR      = 3;
    localparam int         PC_IO0_VAL      = 4;
    localparam int         PC_IO4_DIR      = 5;
    localparam int         PC_IO4_VAL      = 6;
    localparam logic [7:0] PC_USED_MASK    = 8'h7F;
    // Reset values
    localparam logic [7:0] DISP_MODE_RST   = 8'h00;
    localparam logic [3:0] PWR_MODE_RST    = 4'h0;
    localparam logic [6:0] PANEL_CFG_RST   = 7'h00;
    // Encodings
    localparam logic [1:0] BPP_1           = 2'h0;
    localparam logic [1:0] BPP_2           = 2'h1;
    localparam logic [1:0] BPP_4           = 2'h2;
    localparam logic [1:0] BPP_8           = 2'h3;
    localparam logic [3:0] DEPTH_1         = 4'h1;
    localparam logic [3:0] DEPTH_2         = 4'h2;
    localparam logic [3:0] DEPTH_4         = 4'h4;
    localparam logic [3:0] DEPTH_8         = 4'h8;
    localparam logic [2:0] MDIV_8          = 3'h7;
    localparam logic [2:0] MDIV_4          = 3'h3;
    localparam logic [2:0] MDIV_2          = 3'h1;
    localparam logic [2:0] MDIV_1          = 3'h0;
    localparam logic [1:0] SW_PS_SAVE      = 2'h0;
    localparam logic [1:0] SW_PS_NORMAL    = 2'h3;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_DECERR     = 2'h3;
    // Frame repeat counter
    localparam int         FRAME_CNT_W     = 18;
    localparam logic [17:0] FRAME_CNT_MAX  = 18'h3FFFF;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } axi_req_type;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } axi_rsp_type;
endpackage

// ### logic/lcd_mode_power_ctrl.sv
// Mode and power-save control register bank with pixel and pin handling
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module lcd_mode_power_ctrl
    import lcd_mode_pkg::*;
#(
    parameter int PIX_W   = PIX_W_DOC,
    parameter int FRAME_W = FRAME_CNT_W
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire axi_req_type       axi_req,
    output axi_rsp_type            axi_rsp,
    input  wire logic [PIX_W-1:0]  lut_pixel_data,
    output logic      [PIX_W-1:0]  panel_data_lines,
    input  wire logic              panel_data_bit_eleven_in,
    output logic                   panel_data_bit_eleven_out,
    output logic                   panel_data_bit_eleven_oe,
    input  wire logic              general_io_zero_in,
    output logic                   general_io_zero_out,
    output logic                   general_io_zero_oe,
    input  wire logic              frame_start,
    input  wire logic              power_seq_panel_on,
    output logic                   panel_power_output,
    output logic                   stop_delay_one_line,
    output logic                   hw_power_save_req,
    output logic                   sw_power_save,
    output logic                   pixel_clk_en,
    output logic                   memory_clk_en,
    output logic [3:0]             bits_per_pixel,
    output logic                   pattern_restart
);

    // Narrower data would lose the shared bit eleven pin
    if (PIX_W < PIX_W_DOC || FRAME_W < 1) begin : g_bad_width
        $error("PIX_W or FRAME_W out of range");
    end

    localparam logic [FRAME_W-1:0] FRAME_LAST = '1;

    typedef struct packed {
        logic [7:0]             disp_mode;
        logic [3:0]             pwr_mode;
        logic [6:0]             panel_cfg;
        logic                   aw_held;
        logic [ADDR_W-1:0]      aw_addr;
        logic                   w_held;
        logic [7:0]             w_data;
        logic                   w_strb0;
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [7:0]             rdata;
        logic [1:0]             rresp;
        logic                   io0_meta;
        logic                   io0_sync;
        logic                   io11_meta;
        logic                   io11_sync;
        logic                   div_phase;
        logic                   pix_en;
        logic                   mclk_en;
        logic [2:0]             mclk_cnt;
        logic [FRAME_W-1:0]     frame_cnt;
        logic                   restart;
        logic [PIX_W-1:0]       pix;
        logic                   io11_out;
        logic                   io11_oe;
        logic                   io0_out;
        logic                   io0_oe;
        logic                   panel_pwr;
        logic                   short_delay;
        logic                   hw_ps_req;
        logic                   sw_ps;
        logic [3:0]             depth;
    } state_type;

    state_type s_r;
    state_type s_nxt;

    logic       passive;
    logic       landscape;
    logic       hw_inv_pin;
    logic       invert;
    logic [2:0] mdiv_lim;
    logic [7:0] status_word;

    assign passive   = !s_r.panel_cfg[PC_ACTIVE];
    assign landscape = !s_r.panel_cfg[PC_PORTRAIT];
    assign hw_inv_pin = passive && s_r.disp_mode[DM_HW_INV];
    assign status_word = {2'h0, s_r.panel_pwr, s_r.depth == 4'h0,
                          invert, s_r.io11_sync, s_r.io0_sync,
                          s_r.sw_ps || s_r.hw_ps_req};

    always_comb begin
        // Pin level wins over the software bit in passive panels with the hardware invert bit set
        if (hw_inv_pin) begin
            invert = s_r.io11_sync;
        end else begin
            invert = s_r.disp_mode[DM_SW_INV];
        end
        // Portrait ignores the performance bit: depth alone sets the ratio
        if (s_r.disp_mode[DM_HIGH_PERF] && landscape) begin
            mdiv_lim = MDIV_1;
        end else begin
            unique case (s_r.disp_mode[DM_BPP_LO +: 2])
                BPP_1: mdiv_lim = MDIV_8;
                BPP_2: mdiv_lim = MDIV_4;
                BPP_4: mdiv_lim = MDIV_2;
                BPP_8: mdiv_lim = MDIV_1;
            endcase
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.restart = 1'b0;
        s_nxt.io0_meta  = general_io_zero_in;
        s_nxt.io0_sync  = s_r.io0_meta;
        s_nxt.io11_meta = panel_data_bit_eleven_in;
        s_nxt.io11_sync = s_r.io11_meta;

        // Write channel: address and data taken in either order
        if (axi_req.awvalid && s_r.awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s_r.wready) begin
            s_nxt.w_held  = 1'b1;
            s_nxt.w_data  = axi_req.wdata[7:0];
            s_nxt.w_strb0 = axi_req.wstrb[0];
        end
        if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = RESP_OKAY;
            case (s_r.aw_addr)
                ADDR_DISP_MODE: begin
                    if (s_r.w_strb0) begin
                        s_nxt.disp_mode = s_r.w_data;
                    end
                end
                ADDR_PWR_MODE: begin
                    if (s_r.w_strb0) begin
                        s_nxt.pwr_mode = s_r.w_data[3:0];
                    end
                end
                ADDR_PANEL_CFG: begin
                    if (s_r.w_strb0) begin
                        s_nxt.panel_cfg = s_r.w_data[6:0];
                    end
                end
                ADDR_STATUS: s_nxt.bresp = RESP_OKAY;
                default:     s_nxt.bresp = RESP_DECERR;
            endcase
        end
        if (s_r.bvalid && axi_req.bready) begin
            s_nxt.bvalid = 1'b0;
        end
        s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
        s_nxt.wready  = !s_nxt.w_held && !s_nxt.bvalid;

        // Read channel: one outstanding read, answered next cycle
        if (axi_req.arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = RESP_OKAY;
            case (axi_req.araddr)
                ADDR_DISP_MODE: s_nxt.rdata = s_r.disp_mode;
                ADDR_PWR_MODE:  s_nxt.rdata = {4'h0, s_r.pwr_mode};
                ADDR_PANEL_CFG: s_nxt.rdata = {1'b0, s_r.panel_cfg};
                ADDR_STATUS:    s_nxt.rdata = status_word;
                default: begin
                    s_nxt.rdata = 8'h00;
                    s_nxt.rresp = RESP_DECERR;
                end
            endcase
        end else if (s_r.rvalid && axi_req.rready) begin
            s_nxt.rvalid = 1'b0;
        end
        s_nxt.arready = !s_nxt.rvalid;

        // Clock ticks; pixel tick equals operating tick while the divide bit is clear
        if (s_r.disp_mode[DM_CLK_DIV]) begin
            s_nxt.div_phase = !s_r.div_phase;
        end else begin
            s_nxt.div_phase = 1'b0;
        end
        s_nxt.pix_en = !s_r.disp_mode[DM_CLK_DIV] || s_r.div_phase;
        s_nxt.mclk_en = s_nxt.pix_en && (s_r.mclk_cnt == 3'h0);
        if (s_nxt.pix_en) begin
            if (s_r.mclk_cnt >= mdiv_lim) begin
                s_nxt.mclk_cnt = 3'h0;
            end else begin
                s_nxt.mclk_cnt = s_r.mclk_cnt + 3'h1;
            end
        end

        // Depth; mono with code 11 is reserved and reports zero
        unique case (s_r.disp_mode[DM_BPP_LO +: 2])
            BPP_1: s_nxt.depth = DEPTH_1;
            BPP_2: s_nxt.depth = DEPTH_2;
            BPP_4: s_nxt.depth = DEPTH_4;
            BPP_8: begin
                if (s_r.panel_cfg[PC_COLOUR]) begin
                    s_nxt.depth = DEPTH_8;
                end else begin
                    s_nxt.depth = 4'h0;
                end
            end
        endcase

        // Frame counter only runs while repeat is on
        if (!s_r.disp_mode[DM_FRAME_REP]) begin
            s_nxt.frame_cnt = '0;
        end else if (frame_start) begin
            if (s_r.frame_cnt == FRAME_LAST) begin
                s_nxt.frame_cnt = '0;
                s_nxt.restart   = 1'b1;
            end else begin
                s_nxt.frame_cnt = s_r.frame_cnt + FRAME_W'(1);
            end
        end

        // Input is post-table data, so inversion follows the lookup
        if (s_r.disp_mode[DM_BLANK]) begin
            s_nxt.pix = '0;
        end else if (invert) begin
            s_nxt.pix = ~lut_pixel_data;
        end else begin
            s_nxt.pix = lut_pixel_data;
        end

        // Bit eleven pin: data in active panels, invert input or I/O four
        if (!passive) begin
            s_nxt.io11_oe  = 1'b1;
            s_nxt.io11_out = s_nxt.pix[11];
        end else if (hw_inv_pin) begin
            s_nxt.io11_oe  = 1'b0;
            s_nxt.io11_out = 1'b0;
        end else begin
            s_nxt.io11_oe  = s_r.panel_cfg[PC_IO4_DIR];
            s_nxt.io11_out = s_r.panel_cfg[PC_IO4_VAL];
        end

        // General I/O zero doubles as the hardware save input
        if (s_r.pwr_mode[PM_HW_PS]) begin
            s_nxt.io0_oe    = 1'b0;
            s_nxt.io0_out   = 1'b0;
            s_nxt.hw_ps_req = s_r.io0_sync;
        end else begin
            s_nxt.io0_oe    = s_r.panel_cfg[PC_IO0_DIR];
            s_nxt.io0_out   = s_r.panel_cfg[PC_IO0_VAL];
            s_nxt.hw_ps_req = 1'b0;
        end

        s_nxt.panel_pwr   = !s_r.pwr_mode[PM_OVERRIDE] &&
                            power_seq_panel_on;
        s_nxt.short_delay = s_r.pwr_mode[PM_OVERRIDE];
        // Reserved codes keep the previous mode
        unique case (s_r.pwr_mode[PM_SW_PS_LO +: 2])
            SW_PS_SAVE:   s_nxt.sw_ps = 1'b1;
            SW_PS_NORMAL: s_nxt.sw_ps = 1'b0;
            default:      s_nxt.sw_ps = s_r.sw_ps;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_r           <= '0;
            s_r.disp_mode <= DISP_MODE_RST;
            s_r.pwr_mode  <= PWR_MODE_RST;
            s_r.panel_cfg <= PANEL_CFG_RST;
            s_r.sw_ps     <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign axi_rsp.awready = s_r.awready;
    assign axi_rsp.wready  = s_r.wready;
    assign axi_rsp.bvalid  = s_r.bvalid;
    assign axi_rsp.bresp   = s_r.bresp;
    assign axi_rsp.arready = s_r.arready;
    assign axi_rsp.rvalid  = s_r.rvalid;
    assign axi_rsp.rdata   = {24'h0, s_r.rdata};
    assign axi_rsp.rresp   = s_r.rresp;
    assign panel_data_lines          = s_r.pix;
    assign panel_data_bit_eleven_out = s_r.io11_out;
    assign panel_data_bit_eleven_oe  = s_r.io11_oe;
    assign general_io_zero_out       = s_r.io0_out;
    assign general_io_zero_oe        = s_r.io0_oe;
    assign panel_power_output        = s_r.panel_pwr;
    assign stop_delay_one_line       = s_r.short_delay;
    assign hw_power_save_req         = s_r.hw_ps_req;
    assign sw_power_save             = s_r.sw_ps;
    assign pixel_clk_en              = s_r.pix_en;
    assign memory_clk_en             = s_r.mclk_en;
    assign bits_per_pixel            = s_r.depth;
    assign pattern_restart           = s_r.restart;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic c8;
    logic hp_land;
    assign c8 = landscape && !s_r.disp_mode[DM_HIGH_PERF] &&
                !s_r.disp_mode[DM_CLK_DIV] &&
                s_r.disp_mode[DM_BPP_LO +: 2] == BPP_1;
    assign hp_land = landscape && s_r.disp_mode[DM_HIGH_PERF];

    depth_code_a: assert property (
        s_r.disp_mode[DM_BPP_LO +: 2] == BPP_4 |=> bits_per_pixel == 4'h4)
        else $error("depth code 10 not 4 bpp");
    mclk_div8_a: assert property (
        c8[*8] ##1 c8[*8] ##1 (c8 && memory_clk_en)
        |-> $past(memory_clk_en, 8) && !$past(memory_clk_en, 4))
        else $error("memory clock not pixel over 8");
    mclk_fast_a: assert property (
        hp_land[*4] |-> memory_clk_en == pixel_clk_en)
        else $error("memory clock slower than pixel clock");
    clk_half_a: assert property (
        s_r.disp_mode[DM_CLK_DIV][*3] ##0 pixel_clk_en |=> !pixel_clk_en)
        else $error("operating clock not halved");
    blank_low_a: assert property (
        s_r.disp_mode[DM_BLANK] |=> panel_data_lines == '0)
        else $error("blank did not clear data");
    sw_invert_a: assert property (
        !s_r.disp_mode[DM_BLANK] && !s_r.disp_mode[DM_HW_INV] &&
        s_r.disp_mode[DM_SW_INV]
        |=> panel_data_lines == ~$past(lut_pixel_data))
        else $error("software invert not applied");
    hw_invert_a: assert property (
        hw_inv_pin && !s_r.disp_mode[DM_BLANK] && s_r.io11_sync
        |=> panel_data_lines == ~$past(lut_pixel_data) &&
            !panel_data_bit_eleven_oe)
        else $error("pin invert not applied");
    frame_roll_a: assert property (
        s_r.disp_mode[DM_FRAME_REP] && frame_start &&
        s_r.frame_cnt == FRAME_LAST
        |=> pattern_restart && s_r.frame_cnt == '0)
        else $error("frame counter rollover missed");
    no_repeat_a: assert property (
        !s_r.disp_mode[DM_FRAME_REP] |=> !pattern_restart)
        else $error("restart without frame repeat");
    pwr_override_a: assert property (
        s_r.pwr_mode[PM_OVERRIDE] |=> !panel_power_output &&
        stop_delay_one_line)
        else $error("override left panel power on");
    pwr_follow_a: assert property (
        !s_r.pwr_mode[PM_OVERRIDE]
        |=> panel_power_output == $past(power_seq_panel_on))
        else $error("panel power not following sequencer");
    io0_hwps_a: assert property (
        s_r.pwr_mode[PM_HW_PS]
        |=> !general_io_zero_oe && hw_power_save_req == $past(s_r.io0_sync))
        else $error("io zero not save input");
    io0_plain_a: assert property (
        !s_r.pwr_mode[PM_HW_PS]
        |=> general_io_zero_oe == $past(s_r.panel_cfg[PC_IO0_DIR]))
        else $error("io zero direction wrong");
    swps_code_a: assert property (
        s_r.pwr_mode[1:0] == SW_PS_SAVE |=> sw_power_save)
        else $error("save code 00 not honoured");
    pwr_upper_a: assert property (
        axi_req.arvalid && s_r.arready && axi_req.araddr == ADDR_PWR_MODE
        |=> axi_rsp.rvalid && axi_rsp.rdata[7:4] == 4'h0)
        else $error("power mode upper bits not zero");

    write_seen_c: cover property (s_r.bvalid && axi_req.bready);
    rollover_c:   cover property (pattern_restart);
    hw_inv_c:     cover property (hw_inv_pin && s_r.io11_sync);
    hw_save_c:    cover property (hw_power_save_req);

endmodule

// ### test/lcd_mode_and_power_control_bench.sv
// Bench for the mode and power control block
`timescale 1ns/1ps
module lcd_mode_and_power_control_bench;
    import lcd_mode_pkg::*;
    logic        core_clk = 0;
    logic        rst = 1;
    axi_req_type req = '0;
    axi_rsp_type rsp;
    logic [11:0] lut = '0;
    logic [11:0] pdl;
    logic        b11_o, b11_e, b11_p, io_o, io_e, io_p, hwps, swps;
    logic        inv_l = 0, save_l = 0, fs = 0, seq_on = 0;
    logic        pck, mck, prs, ppo, sdl;
    logic [3:0]  bpp;
    logic [31:0] rd;
    logic [1:0]  rr;
    logic [8:0]  pm [6] = '{9'h000, 9'h001, 9'h003, 9'h102, 9'h009, 9'h103};
    int          n_mismatch = 0, compares = 0, p, m;
    // Narrow frame counter so rollovers fit in the run
    localparam int FRW = 4;
    always #25 core_clk = ~core_clk;
    lcd_mode_power_ctrl #(.FRAME_W(FRW)) lcd_mode_power_ctrl_i (
        .core_clk(core_clk),
        .rst(rst), .axi_req(req), .axi_rsp(rsp), .lut_pixel_data(lut),
        .panel_data_lines(pdl), .panel_data_bit_eleven_in(b11_p),
        .panel_data_bit_eleven_out(b11_o), .panel_data_bit_eleven_oe(b11_e),
        .general_io_zero_in(io_p), .general_io_zero_out(io_o),
        .general_io_zero_oe(io_e), .frame_start(fs),
        .power_seq_panel_on(seq_on), .panel_power_output(ppo),
        .stop_delay_one_line(sdl), .hw_power_save_req(hwps),
        .sw_power_save(swps), .pixel_clk_en(pck), .memory_clk_en(mck),
        .bits_per_pixel(bpp), .pattern_restart(prs));
    panel_model panel_model_i (.inv_level(inv_l), .save_level(save_l),
        .bit11_out(b11_o), .bit11_oe(b11_e), .bit11_pin(b11_p),
        .io0_out(io_o), .io0_oe(io_e), .io0_pin(io_p));
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic print_verdict;
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bit ad, wd;
        ad = 0;
        wd = 0;
        @(posedge core_clk);
        req <= '{awvalid:1, awaddr:a, wvalid:1, wdata:{24'h0, d},
                 wstrb:4'hF, bready:1, default:'0};
        while (!(ad && wd)) begin
            @(posedge core_clk);
            if (rsp.awready && req.awvalid)
                ad = 1;
            if (rsp.wready && req.wvalid)
                wd = 1;
            req.awvalid <= !ad;
            req.wvalid <= !wd;
        end
        do @(posedge core_clk); while (!rsp.bvalid);
        rr = rsp.bresp;
        req.bready <= 0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge core_clk);
        req.arvalid <= 1;
        req.araddr <= a;
        req.rready <= 1;
        do @(posedge core_clk); while (!(rsp.arready && req.arvalid));
        req.arvalid <= 0;
        do @(posedge core_clk); while (!rsp.rvalid);
        rd = rsp.rdata;
        rr = rsp.rresp;
        req.rready <= 0;
    endtask
    initial begin
        repeat (60000) @(posedge core_clk);
        n_mismatch++;
        print_verdict;
    end
    initial begin
        logic [11:0] d, e;
        void'($urandom(8));
        repeat (12) @(posedge core_clk);
        rst <= 0;
        seq_on <= 1;
        @(posedge core_clk);
        check(swps, 1'b1);
        // Pixel path: blank wins over invert; pin bit 11 is shared
        foreach (pm[k]) begin
            wr(ADDR_DISP_MODE, pm[k][7:0]);
            inv_l <= pm[k][8];
            repeat (4) @(posedge core_clk);
            repeat (8) begin
                d = 12'($urandom);
                lut <= d;
                @(posedge core_clk);
                #1;
                e = (pm[k][1] ? pm[k][8] : pm[k][0]) ? ~d : d;
                check({b11_e, pdl},
                      {1'b0, pm[k][3] ? 12'h0 : e});
                @(posedge core_clk);
            end
        end
        $display("test pixel done");
        // High performance raised per case, dropped after
        for (int i = 0; i < 32; i++) begin
            wr(ADDR_PANEL_CFG, {5'h0, i[4], 2'b10});
            wr(ADDR_DISP_MODE, {i[1:0], i[2], i[3], 4'h0});
            repeat (20) @(posedge core_clk);
            p = 0;
            m = 0;
            repeat (128) begin
                @(posedge core_clk);
                #1;
                p += pck;
                m += mck;
            end
            check(p, i[3] ? 64 : 128);
            check(m, (i[3] ? 64 : 128) /
                     ((i[2] && !i[4]) ? 1 : 8 >> i[1:0]));
            check(bpp, 4'h1 << i[1:0]);
        end
        wr(ADDR_PANEL_CFG, 8'h00);
        wr(ADDR_DISP_MODE, 8'hC0);
        repeat (2) @(posedge core_clk);
        check(bpp, 4'h0);
        $display("test clocks done");
        rdr(ADDR_PWR_MODE);
        check(rd, 32'h0);
        wr(ADDR_PWR_MODE, 8'hFF);
        rdr(ADDR_PWR_MODE);
        check(rd, 32'h0F);
        check({ppo, sdl, swps}, 3'b010);
        save_l <= 1;
        repeat (4) @(posedge core_clk);
        check(hwps, 1'b1);
        lut <= 12'h800;
        wr(ADDR_PWR_MODE, 8'h03);
        wr(ADDR_PANEL_CFG, 8'h19);
        repeat (4) @(posedge core_clk);
        check({ppo, sdl, hwps, io_e, io_o, b11_e, b11_o},
              7'h4F);
        wr(ADDR_PWR_MODE, 8'h00);
        repeat (2) @(posedge core_clk);
        check(swps, 1'b1);
        rdr(8'h40);
        check(rr, RESP_DECERR);
        wr(8'h40, 8'hFF);
        check(rr, RESP_DECERR);
        $display("test power done");
        // Restart pulse lasts one cycle: sample it at every edge
        for (int j = 0; j < 2; j++) begin
            wr(ADDR_DISP_MODE, j ? 8'h04 : 8'h00);
            m = 0;
            repeat (50) begin
                @(posedge core_clk);
                fs <= 1;
                m += prs;
                @(posedge core_clk);
                fs <= 0;
                m += prs;
            end
            check(m, j ? 50 >> FRW : 0);
        end
        $display("test frame done");
        print_verdict;
    end
endmodule

// ### test/panel_model.sv
// Panel side model: settles the two shared pins
`timescale 1ns/1ps
module panel_model (
    input  wire logic inv_level,
    input  wire logic save_level,
    input  wire logic bit11_out,
    input  wire logic bit11_oe,
    output logic      bit11_pin,
    input  wire logic io0_out,
    input  wire logic io0_oe,
    output logic      io0_pin
);
    // Panel drives a pin only while the controller has released it
    assign bit11_pin = bit11_oe ? bit11_out : inv_level;
    assign io0_pin   = io0_oe ? io0_out : save_level;
endmodule
